// ===== hdl/nfcd_pkg.sv
package nfcd_pkg;

   localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
   localparam logic [7:0] CMD_READ_ID      = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_WORD_PROG    = 8'h40;
   localparam logic [7:0] CMD_BUF_PROG     = 8'hE8;
   localparam logic [7:0] CMD_FACTORY_PROG = 8'h80;
   localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
   localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
   localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
   localparam logic [7:0] CMD_LOCK         = 8'h01;
   localparam logic [7:0] CMD_LOCK_DOWN    = 8'h2F;
   localparam logic [7:0] CMD_SET_RCR      = 8'h03;
   localparam logic [7:0] CMD_OTP_SETUP    = 8'hC0;
   localparam logic [7:0] CMD_BLANK_CHECK  = 8'hBC;
   localparam logic [7:0] CMD_EXT_FUNC     = 8'hEB;

   localparam int SR_READY     = 7;
   localparam int SR_ERASE_SUSP = 6;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR  = 4;
   localparam int SR_PROG_SUSP = 2;
   localparam logic [7:0] SR_RESET = 8'h80;

   localparam int RCR_ADDR_HI = 16;
   localparam int RCR_ADDR_LO = 1;
   localparam logic [15:0] RCR_RESET = 16'hFFFF;

   localparam int MAX_WORDS  = 512;
   localparam int COUNT_W    = 9;

   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_TIME_NS  = 1000;
   localparam int STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int ERASE_STEPS   = 64;

   typedef enum logic [1:0] {
      RD_ARRAY  = 2'h0,
      RD_ID     = 2'h1,
      RD_QUERY  = 2'h2,
      RD_STATUS = 2'h3
   } nfcd_read_t;

   typedef enum logic [2:0] {
      OP_WORD    = 3'h0,
      OP_BUFFER  = 3'h1,
      OP_FACTORY = 3'h2,
      OP_ERASE   = 3'h3,
      OP_BLANK   = 3'h4,
      OP_OTP     = 3'h5,
      OP_EXT     = 3'h6
   } nfcd_op_t;

   typedef enum logic [1:0] {
      LK_LOCK   = 2'h0,
      LK_UNLOCK = 2'h1,
      LK_DOWN   = 2'h2
   } nfcd_lock_t;

   typedef enum logic [3:0] {
      SQ_IDLE       = 4'h0,
      SQ_WORD_DATA  = 4'h1,
      SQ_ERASE_CONF = 4'h2,
      SQ_LOCK_2ND   = 4'h3,
      SQ_BLANK_CONF = 4'h4,
      SQ_OTP_DATA   = 4'h5,
      SQ_BUF_COUNT  = 4'h6,
      SQ_BUF_DATA   = 4'h7,
      SQ_BUF_CONF   = 4'h8,
      SQ_EXT_SUBOP  = 4'h9,
      SQ_EXT_COUNT  = 4'hA,
      SQ_EXT_DATA   = 4'hB,
      SQ_EXT_CONF   = 4'hC,
      SQ_FACT_CONF  = 4'hD,
      SQ_FACT_DATA  = 4'hE
   } nfcd_seq_t;

endpackage : nfcd_pkg

// ===== hdl/nfcd_op_engine.sv
`timescale 1ns/100ps
module nfcd_op_engine #(
   parameter int STEP_CYC = nfcd_pkg::STEP_CYCLES,
   parameter int E_STEPS  = nfcd_pkg::ERASE_STEPS
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   start,
   input  wire nfcd_pkg::nfcd_op_t     kind,
   input  wire logic [8:0]             words,
   input  wire logic                   suspend,
   input  wire logic                   resume,
   output logic                        busy_q,
   output logic                        suspended_q,
   output logic                        done_q,
   output nfcd_pkg::nfcd_op_t          runKind_q
);

   logic [15:0] stepCnt_q;
   logic [15:0] stepsLeft_q;
   logic        stepEnd;

   assign stepEnd = (stepCnt_q == 16'(STEP_CYC - 1));

   always_ff @(posedge clk) begin
      done_q <= 1'b0;
      if (!rst_n) begin
         busy_q      <= 1'b0;
         suspended_q <= 1'b0;
         stepCnt_q   <= 16'h0000;
         stepsLeft_q <= 16'h0000;
         runKind_q   <= nfcd_pkg::OP_WORD;
      end else if (start && !busy_q) begin
         busy_q    <= 1'b1;
         runKind_q <= kind;
         stepCnt_q <= 16'h0000;
         if (kind == nfcd_pkg::OP_ERASE || kind == nfcd_pkg::OP_BLANK)
            stepsLeft_q <= 16'(E_STEPS);
         else
            stepsLeft_q <= {7'h00, words} + 16'h0001;
      end else if (busy_q) begin
         if (suspend && !suspended_q) begin
            suspended_q <= 1'b1; // (R6)
         end else if (resume && suspended_q) begin
            suspended_q <= 1'b0;
         end else if (!suspended_q) begin // (R5)
            if (stepEnd) begin
               stepCnt_q   <= 16'h0000;
               stepsLeft_q <= stepsLeft_q - 16'h0001;
               if (stepsLeft_q == 16'h0001) begin
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end else begin
               stepCnt_q <= stepCnt_q + 16'h0001;
            end
         end
      end
   end

endmodule : nfcd_op_engine

// ===== hdl/nfcd_command_decoder.sv
// Operation
// (R1) 0xBC opens blank check; a confirm write must follow.
// (R2) 0xD0 after blank opener latches block address, runs blank check.
// (R3) extended sequence: 0xEB, sub-op code, count N-1 in 0..511.
// (R4) extended data words fill buffer to count, then 0xD0 completes.
// (R5) accepted program or erase runs as timed steps, no host cycles.
// (R6) reset or suspend stops a running program or erase.
// (R7) host uses the target address on the opening write.
// (R8) 0xFF anywhere returns to array read; code takes it only from the idle sequence state, not while an operation runs.
// (R9) 0x90 selects identifier reads; state persists across reads.
// (R10) 0x98 selects query reads on the 16 data lines.
// (R11) 0x70 then a read returns the status register.
// (R12) 0x50 anywhere clears the status error bits; code clears only from the idle sequence state, not while an operation runs.
// (R13) word program: 0x40 at address, then data to same address.
// (R14) buffered program: 0xE8, count N-1, up to 512 words, 0xD0.
// (R15) factory program: 0x80 then 0xD0, then streamed buffer words.
// (R16) block erase: 0x20 then 0xD0 inside the block.
// (R17) 0xB0 suspends running operation, 0xD0 resumes it.
// (R18) 0x60 then 0x01 lock, 0xD0 unlock, 0x2F lock down.
// (R19) 0xC0 then address and data programs protection or lock register.
// (R20) 0x60 then 0x03 loads read config from address bits 16..1.
// (R21) host adds the die base address on identifier and query reads.
// (R22) bad second write sets both error bits, enters status read.
// (R23) during erase only status read and suspend are accepted.
`timescale 1ns/100ps
module nfcd_command_decoder #(
   parameter int ADDR_W   = 26,
   parameter int STEP_CYC = nfcd_pkg::STEP_CYCLES,
   parameter int E_STEPS  = nfcd_pkg::ERASE_STEPS
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                wrStb,
   input  wire logic [ADDR_W-1:0]   wrAddr,
   input  wire logic [15:0]         wrData,
   input  wire logic                rdStb,
   output nfcd_pkg::nfcd_read_t     readState_q,
   output logic                     rdValid_q,
   output logic [15:0]              rdData_q,
   output logic [7:0]               status_q,
   output logic                     opStart_q,
   output nfcd_pkg::nfcd_op_t       opKind_q,
   output logic [ADDR_W-1:0]        opAddr_q,
   output logic [15:0]              opData_q,
   output logic [8:0]               opWords_q,
   output logic [7:0]               subOp_q,
   output logic                     bufWe_q,
   output logic [8:0]               bufIdx_q,
   output logic [15:0]              bufData_q,
   output logic                     lockWe_q,
   output nfcd_pkg::nfcd_lock_t     lockAction_q,
   output logic [15:0]              rcr_q,
   output logic                     busy_q,
   output logic                     suspended_q,
   output logic                     opDone_q
);

   nfcd_pkg::nfcd_seq_t seq_q;
   logic [7:0]          code;
   logic                engBusy;
   logic                engSusp;
   logic                engDone;
   nfcd_pkg::nfcd_op_t  engKind;
   logic                suspReq_q;
   logic                resumeReq_q;
   logic [8:0]          count_q;
   logic                running;
   logic                take;
   logic                seqErr;

   assign code    = wrData[7:0];
   assign running = engBusy && !engSusp;
   // while timed work runs only status read and suspend are decoded
   assign take = wrStb && (!running || code == nfcd_pkg::CMD_READ_STATUS
                           || code == nfcd_pkg::CMD_SUSPEND); // (R23)

   function automatic logic isOpener(input logic [7:0] c);
      isOpener = (c == nfcd_pkg::CMD_WORD_PROG)   ||
                 (c == nfcd_pkg::CMD_BUF_PROG)    ||
                 (c == nfcd_pkg::CMD_FACTORY_PROG)||
                 (c == nfcd_pkg::CMD_ERASE_SETUP) ||
                 (c == nfcd_pkg::CMD_LOCK_SETUP)  ||
                 (c == nfcd_pkg::CMD_OTP_SETUP)   ||
                 (c == nfcd_pkg::CMD_BLANK_CHECK) ||
                 (c == nfcd_pkg::CMD_EXT_FUNC);
   endfunction : isOpener

   function automatic logic [8:0] lowCount(input logic [15:0] d);
      lowCount = d[8:0];
   endfunction : lowCount

   localparam int COUNT_HI = nfcd_pkg::COUNT_W;

   // confirm or lock write that does not complete its opener, or a count above 511
   always_comb begin
      seqErr = 1'b0;
      if (take) begin
         unique case (seq_q)
            nfcd_pkg::SQ_ERASE_CONF,
            nfcd_pkg::SQ_BLANK_CONF,
            nfcd_pkg::SQ_FACT_CONF,
            nfcd_pkg::SQ_BUF_CONF,
            nfcd_pkg::SQ_EXT_CONF:
               seqErr = (code != nfcd_pkg::CMD_CONFIRM); // (R22)
            nfcd_pkg::SQ_LOCK_2ND:
               seqErr = (code != nfcd_pkg::CMD_LOCK) &&
                        (code != nfcd_pkg::CMD_CONFIRM) &&
                        (code != nfcd_pkg::CMD_LOCK_DOWN) &&
                        (code != nfcd_pkg::CMD_SET_RCR); // (R22)
            nfcd_pkg::SQ_BUF_COUNT,
            nfcd_pkg::SQ_EXT_COUNT:
               seqErr = (wrData[15:COUNT_HI] != '0);
            default:
               seqErr = 1'b0;
         endcase
      end
   end

   // command sequencer
   always_ff @(posedge clk) begin
      opStart_q <= 1'b0;
      bufWe_q   <= 1'b0;
      lockWe_q  <= 1'b0;
      if (!rst_n) begin
         seq_q        <= nfcd_pkg::SQ_IDLE;
         opKind_q     <= nfcd_pkg::OP_WORD;
         opAddr_q     <= '0;
         opData_q     <= 16'h0000;
         opWords_q    <= 9'h000;
         subOp_q      <= 8'h00;
         count_q      <= 9'h000;
         bufIdx_q     <= 9'h000;
         bufData_q    <= 16'h0000;
         lockAction_q <= nfcd_pkg::LK_LOCK;
         rcr_q        <= nfcd_pkg::RCR_RESET;
      end else if (take) begin
         if (seqErr) begin
            seq_q <= nfcd_pkg::SQ_IDLE;
         end else begin
            unique case (seq_q)
               nfcd_pkg::SQ_IDLE: begin
                  opAddr_q <= wrAddr; // (R7)
                  unique case (code)
                     nfcd_pkg::CMD_WORD_PROG:
                        seq_q <= nfcd_pkg::SQ_WORD_DATA; // (R13)
                     nfcd_pkg::CMD_BUF_PROG:
                        seq_q <= nfcd_pkg::SQ_BUF_COUNT; // (R14)
                     nfcd_pkg::CMD_FACTORY_PROG:
                        seq_q <= nfcd_pkg::SQ_FACT_CONF; // (R15)
                     nfcd_pkg::CMD_ERASE_SETUP:
                        seq_q <= nfcd_pkg::SQ_ERASE_CONF; // (R16)
                     nfcd_pkg::CMD_LOCK_SETUP:
                        seq_q <= nfcd_pkg::SQ_LOCK_2ND;
                     nfcd_pkg::CMD_OTP_SETUP:
                        seq_q <= nfcd_pkg::SQ_OTP_DATA;
                     nfcd_pkg::CMD_BLANK_CHECK:
                        seq_q <= nfcd_pkg::SQ_BLANK_CONF; // (R1)
                     nfcd_pkg::CMD_EXT_FUNC:
                        seq_q <= nfcd_pkg::SQ_EXT_SUBOP; // (R3)
                     default:
                        seq_q <= nfcd_pkg::SQ_IDLE;
                  endcase
               end
               nfcd_pkg::SQ_WORD_DATA: begin
                  opAddr_q  <= wrAddr;
                  opData_q  <= wrData;
                  opWords_q <= 9'h000;
                  opKind_q  <= nfcd_pkg::OP_WORD;
                  opStart_q <= 1'b1; // (R13)
                  seq_q     <= nfcd_pkg::SQ_IDLE;
               end
               nfcd_pkg::SQ_ERASE_CONF: begin
                  opAddr_q  <= wrAddr;
                  opKind_q  <= nfcd_pkg::OP_ERASE;
                  opStart_q <= 1'b1; // (R16)
                  seq_q     <= nfcd_pkg::SQ_IDLE;
               end
               nfcd_pkg::SQ_BLANK_CONF: begin
                  opAddr_q  <= wrAddr; // (R2)
                  opKind_q  <= nfcd_pkg::OP_BLANK;
                  opStart_q <= 1'b1; // (R2)
                  seq_q     <= nfcd_pkg::SQ_IDLE;
               end
               nfcd_pkg::SQ_LOCK_2ND: begin
                  seq_q <= nfcd_pkg::SQ_IDLE;
                  if (code == nfcd_pkg::CMD_SET_RCR) begin
                     rcr_q <= wrAddr[nfcd_pkg::RCR_ADDR_HI:
                                     nfcd_pkg::RCR_ADDR_LO]; // (R20)
                  end else begin
                     opAddr_q <= wrAddr;
                     lockWe_q <= 1'b1; // (R18)
                     if (code == nfcd_pkg::CMD_LOCK)
                        lockAction_q <= nfcd_pkg::LK_LOCK;
                     else if (code == nfcd_pkg::CMD_LOCK_DOWN)
                        lockAction_q <= nfcd_pkg::LK_DOWN;
                     else
                        lockAction_q <= nfcd_pkg::LK_UNLOCK;
                  end
               end
               nfcd_pkg::SQ_OTP_DATA: begin
                  opAddr_q  <= wrAddr;
                  opData_q  <= wrData;
                  opWords_q <= 9'h000;
                  opKind_q  <= nfcd_pkg::OP_OTP;
                  opStart_q <= 1'b1; // (R19)
                  seq_q     <= nfcd_pkg::SQ_IDLE;
               end
               nfcd_pkg::SQ_BUF_COUNT,
               nfcd_pkg::SQ_EXT_COUNT: begin
                  count_q   <= lowCount(wrData); // (R14)
                  opWords_q <= lowCount(wrData);
                  bufIdx_q  <= 9'h1FF;
                  seq_q     <= (seq_q == nfcd_pkg::SQ_BUF_COUNT) ?
                               nfcd_pkg::SQ_BUF_DATA :
                               nfcd_pkg::SQ_EXT_DATA; // (R3)
               end
               nfcd_pkg::SQ_BUF_DATA,
               nfcd_pkg::SQ_EXT_DATA,
               nfcd_pkg::SQ_FACT_DATA: begin
                  bufWe_q   <= 1'b1; // (R4)
                  bufIdx_q  <= bufIdx_q + 9'h001;
                  bufData_q <= wrData;
                  if (bufIdx_q + 9'h001 == count_q) begin
                     if (seq_q == nfcd_pkg::SQ_FACT_DATA) begin
                        opKind_q  <= nfcd_pkg::OP_FACTORY;
                        opStart_q <= 1'b1; // (R15)
                        seq_q     <= nfcd_pkg::SQ_IDLE;
                     end else begin
                        seq_q <= (seq_q == nfcd_pkg::SQ_BUF_DATA) ?
                                 nfcd_pkg::SQ_BUF_CONF :
                                 nfcd_pkg::SQ_EXT_CONF; // (R4)
                     end
                  end
               end
               nfcd_pkg::SQ_BUF_CONF: begin
                  opKind_q  <= nfcd_pkg::OP_BUFFER;
                  opStart_q <= 1'b1; // (R14)
                  seq_q     <= nfcd_pkg::SQ_IDLE;
               end
               nfcd_pkg::SQ_EXT_CONF: begin
                  opKind_q  <= nfcd_pkg::OP_EXT;
                  opStart_q <= 1'b1; // (R4)
                  seq_q     <= nfcd_pkg::SQ_IDLE;
               end
               nfcd_pkg::SQ_EXT_SUBOP: begin
                  subOp_q <= code; // (R3)
                  seq_q   <= nfcd_pkg::SQ_EXT_COUNT;
               end
               nfcd_pkg::SQ_FACT_CONF: begin
                  // factory stream always fills the whole buffer
                  opAddr_q  <= wrAddr;
                  count_q   <= 9'(nfcd_pkg::MAX_WORDS - 1);
                  opWords_q <= 9'(nfcd_pkg::MAX_WORDS - 1);
                  bufIdx_q  <= 9'h1FF;
                  seq_q     <= nfcd_pkg::SQ_FACT_DATA; // (R15)
               end
               default:
                  seq_q <= nfcd_pkg::SQ_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         suspReq_q   <= 1'b0;
         resumeReq_q <= 1'b0;
      end else begin
         suspReq_q   <= take && seq_q == nfcd_pkg::SQ_IDLE &&
                        code == nfcd_pkg::CMD_SUSPEND; // (R17)
         resumeReq_q <= take && seq_q == nfcd_pkg::SQ_IDLE &&
                        engSusp && code == nfcd_pkg::CMD_CONFIRM; // (R17)
      end
   end

   // read state selection
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readState_q <= nfcd_pkg::RD_ARRAY;
      end else if (seqErr) begin
         readState_q <= nfcd_pkg::RD_STATUS; // (R22)
      end else if (take && seq_q == nfcd_pkg::SQ_IDLE) begin
         unique case (code)
            nfcd_pkg::CMD_READ_ARRAY:
               readState_q <= nfcd_pkg::RD_ARRAY; // (R8)
            nfcd_pkg::CMD_READ_ID:
               readState_q <= nfcd_pkg::RD_ID; // (R9)
            nfcd_pkg::CMD_READ_QUERY:
               readState_q <= nfcd_pkg::RD_QUERY; // (R10)
            nfcd_pkg::CMD_READ_STATUS:
               readState_q <= nfcd_pkg::RD_STATUS; // (R11)
            default:
               if (isOpener(code) || code == nfcd_pkg::CMD_SUSPEND)
                  readState_q <= nfcd_pkg::RD_STATUS;
         endcase
      end else if (take && seq_q == nfcd_pkg::SQ_LOCK_2ND &&
                   code == nfcd_pkg::CMD_SET_RCR) begin
         readState_q <= nfcd_pkg::RD_ARRAY; // (R20)
      end
   end

   // status register: error set wins over a clear in the same write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_q <= nfcd_pkg::SR_RESET;
      end else begin
         status_q[nfcd_pkg::SR_READY]      <= !engBusy || engSusp;
         status_q[nfcd_pkg::SR_ERASE_SUSP] <= engSusp &&
                                              engKind == nfcd_pkg::OP_ERASE;
         status_q[nfcd_pkg::SR_PROG_SUSP]  <= engSusp &&
                                              engKind != nfcd_pkg::OP_ERASE;
         if (seqErr) begin
            status_q[nfcd_pkg::SR_ERASE_ERR] <= 1'b1; // (R22)
            status_q[nfcd_pkg::SR_PROG_ERR]  <= 1'b1; // (R22)
         end else if (take && seq_q == nfcd_pkg::SQ_IDLE &&
                      code == nfcd_pkg::CMD_CLEAR_STATUS) begin
            status_q[nfcd_pkg::SR_ERASE_ERR] <= 1'b0; // (R12)
            status_q[nfcd_pkg::SR_PROG_ERR]  <= 1'b0; // (R12)
         end
      end
   end

   // read answer; non-status contents are muxed outside by readState_q
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdValid_q <= 1'b0;
         rdData_q  <= 16'h0000;
      end else begin
         rdValid_q <= rdStb;
         if (rdStb)
            rdData_q <= (readState_q == nfcd_pkg::RD_STATUS) ?
                        {8'h00, status_q} : 16'h0000; // (R11)
      end
   end

   nfcd_op_engine #(
      .STEP_CYC (STEP_CYC),
      .E_STEPS  (E_STEPS)
   ) u_engine (
      .clk         (clk),
      .rst_n       (rst_n),
      .start       (opStart_q),
      .kind        (opKind_q),
      .words       (opWords_q),
      .suspend     (suspReq_q),
      .resume      (resumeReq_q),
      .busy_q      (engBusy),
      .suspended_q (engSusp),
      .done_q      (engDone),
      .runKind_q   (engKind)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy_q      <= 1'b0;
         suspended_q <= 1'b0;
         opDone_q    <= 1'b0;
      end else begin
         busy_q      <= engBusy; // (R5)
         suspended_q <= engSusp; // (R6)
         opDone_q    <= engDone;
      end
   end

endmodule : nfcd_command_decoder

// ===== testbench/nfcd_asserts.sv
`timescale 1ns/100ps
module nfcd_asserts #(
   parameter int ADDR_W = 26
) (
   input wire logic                 clk,
   input wire logic                 rst_n,
   input wire logic                 wrStb,
   input wire logic [ADDR_W-1:0]    wrAddr,
   input wire logic [15:0]          wrData,
   input wire logic                 rdStb,
   input wire nfcd_pkg::nfcd_read_t readState_q,
   input wire logic                 rdValid_q,
   input wire logic [15:0]          rdData_q,
   input wire logic [7:0]           status_q,
   input wire logic                 opStart_q,
   input wire nfcd_pkg::nfcd_op_t   opKind_q,
   input wire logic [15:0]          opData_q,
   input wire logic [15:0]          rcr_q,
   input wire logic                 busy_q,
   input wire logic                 suspended_q
);
   logic [7:0] cmd;
   logic       idle;
   assign cmd  = wrData[7:0];
   assign idle = !busy_q || suspended_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   read_array_a: assert property (wrStb && cmd == 8'hFF && idle
      |=> readState_q == nfcd_pkg::RD_ARRAY) else $error("no array read");
   id_hold_a: assert property (wrStb && cmd == 8'h90 && idle
      ##1 !wrStb [*2] |-> readState_q == nfcd_pkg::RD_ID)
      else $error("identifier state lost");
   status_read_a: assert property (rdStb && readState_q == 2'h3
      |=> rdValid_q && rdData_q == {8'h00, $past(status_q)})
      else $error("status read data wrong");
   clear_err_a: assert property (wrStb && cmd == 8'h50 && idle
      |=> status_q[5:4] == 2'h0) else $error("errors not cleared");
   word_start_a: assert property (wrStb && cmd == 8'h40 && !busy_q
      ##1 !wrStb ##1 wrStb |=> opStart_q && opKind_q == 3'h0
      && opData_q == $past(wrData)) else $error("word program not started");
   busy_follow_a: assert property (opStart_q |-> ##2 busy_q)
      else $error("operation not running");
   suspend_stop_a: assert property (busy_q && !suspended_q && wrStb
      && cmd == 8'hB0 |-> ##[1:4] suspended_q) else $error("no suspend");
   busy_ignore_a: assert property (busy_q && !suspended_q && wrStb
      && cmd == 8'hFF |=> $stable(readState_q)) else $error("not ignored");
   bad_second_a: assert property (wrStb && cmd == 8'h20 && !busy_q
      ##1 !wrStb ##1 (wrStb && cmd != 8'hD0)
      |=> status_q[5:4] == 2'h3 && readState_q == nfcd_pkg::RD_STATUS)
      else $error("sequence error not flagged");
   rcr_load_a: assert property (wrStb && cmd == 8'h60 && !busy_q
      ##1 !wrStb ##1 (wrStb && cmd == 8'h03) |=> rcr_q == $past(
      wrAddr[16:1]) && readState_q == 2'h0) else $error("rcr not loaded");
   cover property (opStart_q && opKind_q == nfcd_pkg::OP_ERASE);
   cover property (suspended_q);
   cover property (opStart_q && opKind_q == nfcd_pkg::OP_FACTORY);
endmodule : nfcd_asserts

bind nfcd_command_decoder nfcd_asserts #(.ADDR_W(ADDR_W)) i_asserts (
   .clk, .rst_n, .wrStb, .wrAddr, .wrData, .rdStb, .readState_q,
   .rdValid_q, .rdData_q, .status_q, .opStart_q, .opKind_q, .opData_q,
   .rcr_q, .busy_q, .suspended_q);

// ===== testbench/nfcd_host.sv
`timescale 1ns/100ps
module nfcd_host (
   input  wire logic   clk,
   output logic        wrStb,
   output logic [25:0] wrAddr,
   output logic [15:0] wrData,
   output logic        rdStb
);
   initial begin
      wrStb  = 1'h0;
      rdStb  = 1'h0;
      wrAddr = 26'h0;
      wrData = 16'h0;
   end
   task automatic wr(input logic [25:0] a, input logic [15:0] d);
      @(posedge clk);
      wrStb  <= 1'h1;
      wrAddr <= a;
      wrData <= d;
      @(posedge clk);
      wrStb  <= 1'h0;
      wrAddr <= ~a;
      wrData <= ~d;
      #1;
   endtask : wr
   task automatic rd();
      @(posedge clk);
      rdStb <= 1'h1;
      @(posedge clk);
      rdStb <= 1'h0;
      #1;
   endtask : rd
endmodule : nfcd_host

// ===== testbench/nfcd_command_decoder_tb_top.sv
`timescale 1ns/100ps
module nfcd_command_decoder_tb_top;
   logic clk, rst_n, wrStb, rdStb, rdValid_q, opStart_q, bufWe_q;
   logic lockWe_q, busy_q, suspended_q, opDone_q;
   logic [25:0] wrAddr, opAddr_q;
   logic [15:0] wrData, rdData_q, opData_q, bufData_q, rcr_q;
   logic [8:0]  opWords_q, bufIdx_q;
   logic [7:0]  status_q, subOp_q;
   nfcd_pkg::nfcd_read_t readState_q;
   nfcd_pkg::nfcd_op_t   opKind_q;
   nfcd_pkg::nfcd_lock_t lockAction_q;
   int error_cnt = 0;
   int comparisons = 0;
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   nfcd_host i_host (.clk, .wrStb, .wrAddr, .wrData, .rdStb);
   nfcd_command_decoder #(.STEP_CYC(2), .E_STEPS(8)) i_dut (.clk, .rst_n,
      .wrStb, .wrAddr, .wrData, .rdStb, .readState_q, .rdValid_q,
      .rdData_q, .status_q, .opStart_q, .opKind_q, .opAddr_q, .opData_q,
      .opWords_q, .subOp_q, .bufWe_q, .bufIdx_q, .bufData_q, .lockWe_q,
      .lockAction_q, .rcr_q, .busy_q, .suspended_q, .opDone_q);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic w(input logic [25:0] a, input logic [15:0] d);
      i_host.wr(a, d);
   endtask : w
   task automatic wait_done();
      for (int n = 0; n < 2000 && opDone_q !== 1'h1; n++) begin
         @(posedge clk);
         #1;
      end
      chk(opDone_q, 1'h1);
   endtask : wait_done
   task automatic t_reads();
      chk({status_q, rcr_q}, 24'h80FFFF);
      w(26'h100, 16'h90);
      i_host.rd();
      chk(readState_q, 2'h1);
      w(26'h200, 16'h98);
      chk(readState_q, 2'h2);
      w(26'h300, 16'h70);
      i_host.rd();
      chk({rdValid_q, rdData_q}, 17'h10080);
      w(26'h3FFFFFF, 16'hFF);
      chk(readState_q, 2'h0);
   endtask : t_reads
   task automatic t_word();
      w(26'h12340, 16'h40);
      w(26'h12340, 16'hA55A);
      chk({opStart_q, opKind_q, opData_q}, 20'h8A55A);
      chk(opAddr_q, 26'h12340);
      wait_done();
      w(26'h85, 16'hC0);
      w(26'h85, 16'hBEEF);
      chk({opStart_q, opKind_q, opData_q}, 20'hDBEEF);
      wait_done();
   endtask : t_word
   task automatic t_erase();
      w(26'h420000, 16'h20);
      w(26'h420000, 16'hD0);
      chk({opStart_q, opKind_q}, 4'hB);
      repeat (2) @(posedge clk);
      w(26'h0, 16'hFF);
      chk(readState_q, 2'h3);
      w(26'h0, 16'hB0);
      repeat (3) @(posedge clk);
      #1;
      chk({suspended_q, status_q[7:6]}, 3'h7);
      w(26'h0, 16'hD0);
      repeat (2) @(posedge clk);
      #1;
      chk(suspended_q, 1'h0);
      wait_done();
      w(26'h440000, 16'h20);
      w(26'h440000, 16'hD0);
      repeat (3) @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      chk({busy_q, status_q}, 9'h080);
   endtask : t_erase
   task automatic t_lock();
      logic [7:0] c [3] = '{8'h01, 8'hD0, 8'h2F};
      for (int i = 0; i < 3; i++) begin
         w(26'h60000, 16'h60);
         w(26'h60000, {8'h00, c[i]});
         chk({lockWe_q, lockAction_q}, {1'h1, i[1:0]});
      end
      w(26'h15554, 16'h60);
      w(26'h15554, 16'h03);
      chk({rcr_q, readState_q}, {16'hAAAA, 2'h0});
   endtask : t_lock
   task automatic t_refuse();
      logic [7:0] op [3] = '{8'h20, 8'hBC, 8'h60};
      foreach (op[i]) begin
         w(26'h0, {8'h00, op[i]});
         w(26'h0, 16'h41);
         chk({status_q[5:4], readState_q}, 4'hF);
         w(26'h0, 16'h50);
         chk(status_q[5:4], 2'h0);
      end
      w(26'h80000, 16'hBC);
      w(26'h80000, 16'hD0);
      chk({opStart_q, opKind_q, opAddr_q}, {4'hC, 26'h80000});
      wait_done();
   endtask : t_refuse
   task automatic t_buf();
      w(26'h100000, 16'hE8);
      w(26'h100000, 16'h01);
      for (int i = 0; i < 2; i++) begin
         w(26'h100000, 16'hC000 + i[15:0]);
         chk({bufWe_q, bufIdx_q}, {1'h1, i[8:0]});
      end
      w(26'h100000, 16'hD0);
      chk({opStart_q, opKind_q, opWords_q}, 13'h1201);
      wait_done();
      w(26'h0, 16'hEB);
      w(26'h0, 16'h5A);
      w(26'h0, 16'h00);
      w(26'h0, 16'h1234);
      chk({bufWe_q, bufData_q}, 17'h11234);
      w(26'h0, 16'hD0);
      chk({opStart_q, opKind_q, subOp_q}, 12'hE5A);
      wait_done();
      w(26'h200000, 16'h80);
      w(26'h200000, 16'hD0);
      for (int i = 0; i < 512; i++) begin
         w(26'h200000, {i[8:0], 7'h00});
      end
      chk({opStart_q, opKind_q, bufIdx_q}, 13'h15FF);
      wait_done();
   endtask : t_buf
   task automatic complete_run();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   initial begin
      rst_n = 1'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      t_reads();
      t_word();
      t_erase();
      t_lock();
      t_refuse();
      t_buf();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      complete_run();
   end
endmodule : nfcd_command_decoder_tb_top
